// [src/hall_trim_pkg.sv]
/*
 * Constants of the sensor trim path: register offsets, field positions,
 * reset values and fixed-point scaling of every trim coefficient.
 * Assumes a 32-bit register port with byte addresses on word boundaries.
 */
package hall_trim_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_SENS_TRIM = 8'h00;
    localparam logic [7:0] REG_GAIN_TC_FIRST = 8'h04;
    localparam logic [7:0] REG_GAIN_TC_SECOND = 8'h08;
    localparam logic [7:0] REG_OFFSET_TRIM = 8'h0C;
    localparam logic [7:0] REG_OFFSET_TC = 8'h10;
    localparam logic [7:0] REG_CLAMP = 8'h14;
    localparam logic [7:0] REG_POST = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    localparam logic [7:0] REG_BREAKPOINT = 8'h40;
    // Field positions
    localparam int POL_BIT = 15;
    localparam int COARSE_LSB = 12;
    localparam int CHILL_LSB = 12;
    localparam int HIGH_CLAMP_LSB = 16;
    localparam int POST_OFFSET_LSB = 16;
    localparam int POL_IN_BIT = 28;
    localparam int POL_OUT_BIT = 29;
    // Widths
    localparam int COARSE_W = 3;
    localparam int FINE_W = 11;
    localparam int TC1_W = 11;
    localparam int TC2_W = 10;
    localparam int OFS_W = 16;
    localparam int OTC_W = 12;
    localparam int CLAMP_W = 12;
    localparam int POST_W = 12;
    localparam int BP_W = 12;
    localparam int BP_NUM = 17;
    // Reset values
    localparam logic [10:0] FINE_RESET = 11'h400;
    localparam logic [11:0] HIGH_CLAMP_RESET = 12'hFFF;
    localparam logic [11:0] POST_GAIN_RESET = 12'h7FF;
    // Fixed-point scaling
    localparam int FINE_UNITY = 1024;
    localparam int FINE_SHIFT = 11;
    localparam int COARSE_MAX_SHIFT = 5;
    localparam int FACTOR_SHIFT = 25;
    localparam int TC1_WARM_SHIFT = 7;
    localparam int TC1_CHILL_SHIFT = 8;
    localparam int TC2_WARM_SHIFT = 0;
    localparam int TC2_CHILL_SHIFT = 2;
    localparam int OTC_WARM_SHIFT = 6;
    localparam int OTC_CHILL_SHIFT = 5;
    localparam int POST_SHIFT = 11;
    localparam int REF_TEMP = 25;
    localparam int Y1_MIN = -65536;
    localparam int Y1_MAX = 65535;
    localparam int Y2_MIN = -4096;
    localparam int Y2_MAX = 4095;
    localparam int LIN_Y0 = -2048;
    localparam int LIN_STEP = 256;
    localparam int LIN_LIMIT = 2304;
    localparam int OUT_MID = 2048;
    localparam int OUT_MAX = 4095;
endpackage

// [src/hall_signal_trim_path.sv]
/*
 * Digital trim path of a linear magnetic sensor: gain trim with
 * temperature correction, offset trim with drift correction,
 * 17-point linearisation, post gain/offset and output clamps.
 * Assumes samples and temperature synchronous to clk_sys; the register
 * port is a plain strobe port with read data one cycle after the read.
 */
// Chosen here: the register addresses and strobed register access.
module hall_signal_trim_path
    import hall_trim_pkg::*;
#(
    parameter int SAMPLE_W = 16,
    parameter int TEMP_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    output logic [31:0] regRdData,
    input wire logic signed [SAMPLE_W-1:0] sampleIn,
    input wire logic sampleValid,
    input wire logic signed [TEMP_W-1:0] ambientTemp,
    output logic [11:0] outCode,
    output logic outValid
);
    // Trim settings
    logic polarity;
    logic [COARSE_W-1:0] coarseGain;
    logic [FINE_W-1:0] fineGain;
    logic signed [TC1_W-1:0] gain_tc_first_warm, gain_tc_first_chill;
    logic signed [TC2_W-1:0] gain_tc_second_warm, gain_tc_second_chill;
    logic signed [OFS_W-1:0] offset_trim;
    logic signed [OTC_W-1:0] offsetTcWarm, offsetTcChill;
    logic [CLAMP_W-1:0] low_clamp_limit, high_clamp_limit;
    logic signed [POST_W-1:0] post_gain_trim, post_offset_trim;
    logic polIn, polOut;
    logic signed [BP_W-1:0] segment_breakpoint [BP_NUM];

    function automatic logic signed [63:0] clip(input logic signed [63:0] v,
            input logic signed [63:0] lo, input logic signed [63:0] hi);
        clip = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    wire logic bpHit = regAddr >= REG_BREAKPOINT && regAddr[1:0] == 2'b00
        && regAddr < REG_BREAKPOINT + 8'(BP_NUM * 4);
    wire logic [4:0] bpIdx = 5'((regAddr - REG_BREAKPOINT) >> 2);

    // Register writes; all trims power up neutral
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            polarity <= 1'b0;
            coarseGain <= '0;
            fineGain <= FINE_RESET;
            gain_tc_first_warm <= '0;
            gain_tc_first_chill <= '0;
            gain_tc_second_warm <= '0;
            gain_tc_second_chill <= '0;
            offset_trim <= '0;
            offsetTcWarm <= '0;
            offsetTcChill <= '0;
            low_clamp_limit <= '0;
            high_clamp_limit <= HIGH_CLAMP_RESET;
            post_gain_trim <= POST_GAIN_RESET;
            post_offset_trim <= '0;
            polIn <= 1'b0;
            polOut <= 1'b0;
        end else if (regWr) begin
            unique case (regAddr)
                REG_SENS_TRIM: begin
                    polarity <= regWrData[POL_BIT];
                    coarseGain <= regWrData[COARSE_LSB +: COARSE_W];
                    fineGain <= regWrData[FINE_W-1:0];
                end
                REG_GAIN_TC_FIRST: begin
                    gain_tc_first_warm <= regWrData[TC1_W-1:0];
                    gain_tc_first_chill <= regWrData[CHILL_LSB +: TC1_W];
                end
                REG_GAIN_TC_SECOND: begin
                    gain_tc_second_warm <= regWrData[TC2_W-1:0];
                    gain_tc_second_chill <= regWrData[CHILL_LSB +: TC2_W];
                end
                REG_OFFSET_TRIM: offset_trim <= regWrData[OFS_W-1:0];
                REG_OFFSET_TC: begin
                    offsetTcWarm <= regWrData[OTC_W-1:0];
                    offsetTcChill <= regWrData[CHILL_LSB +: OTC_W];
                end
                REG_CLAMP: begin
                    low_clamp_limit <= regWrData[CLAMP_W-1:0];
                    high_clamp_limit <= regWrData[HIGH_CLAMP_LSB +: CLAMP_W];
                end
                REG_POST: begin
                    post_gain_trim <= regWrData[POST_W-1:0];
                    post_offset_trim <= regWrData[POST_OFFSET_LSB +: POST_W];
                    polIn <= regWrData[POL_IN_BIT];
                    polOut <= regWrData[POL_OUT_BIT];
                end
                default: ;
            endcase
        end
    end

    // Breakpoint table, reset to an evenly spread identity-like layout except the top entry, which wraps to -2048
    generate
        for (genvar i = 0; i < BP_NUM; i++) begin : gBp
            always_ff @(posedge clk_sys or posedge sys_rst) begin
                if (sys_rst) begin
                    segment_breakpoint[i] <= BP_W'(LIN_Y0 + LIN_STEP * i);
                end else if (regWr && bpHit && bpIdx == 5'(i)) begin
                    segment_breakpoint[i] <= regWrData[BP_W-1:0];
                end
            end
        end
    endgenerate

    // Read port; unmapped addresses read zero
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            regRdData <= '0;
        end else if (regRd) begin
            regRdData <= '0;
            if (bpHit) begin
                regRdData <= {20'h00000, segment_breakpoint[bpIdx]};
            end else begin
                unique case (regAddr)
                    REG_SENS_TRIM: regRdData <= {16'h0000, polarity, coarseGain, 1'b0, fineGain};
                    REG_GAIN_TC_FIRST: regRdData <= {9'h000, gain_tc_first_chill, 1'b0,
                        gain_tc_first_warm};
                    REG_GAIN_TC_SECOND: regRdData <= {10'h000, gain_tc_second_chill, 2'b00,
                        gain_tc_second_warm};
                    REG_OFFSET_TRIM: regRdData <= {16'h0000, offset_trim};
                    REG_OFFSET_TC: regRdData <= {8'h00, offsetTcChill, offsetTcWarm};
                    REG_CLAMP: regRdData <= {4'h0, high_clamp_limit, 4'h0, low_clamp_limit};
                    REG_POST: regRdData <= {2'b00, polOut, polIn, post_offset_trim, 4'h0,
                        post_gain_trim};
                    REG_STATUS: regRdData <= {20'h00000, outCode};
                    default: regRdData <= '0;
                endcase
            end
        end
    end

    // Gain stage: the signed sample scaled by coarse then fine gain, then by
    // the temperature factor; 64-bit intermediates avoid any silent wrap
    logic signed [9:0] deltaT;
    logic warm;
    logic signed [63:0] scaled, tcTerm, product, next_y1;
    always_comb begin
        deltaT = 10'(ambientTemp) - 10'(REF_TEMP);
        warm = !deltaT[9];
        // Coarse then fine, in that order
        scaled = 64'(sampleIn) <<< ((coarseGain > COARSE_MAX_SHIFT) ?
            COARSE_MAX_SHIFT : int'(coarseGain));
        scaled = (scaled * 64'(FINE_UNITY + int'(fineGain))) >>> FINE_SHIFT;
        // First and second order terms of the region in force
        if (warm) begin
            tcTerm = ((64'(gain_tc_first_warm) * 64'(deltaT)) <<< TC1_WARM_SHIFT)
                + ((64'(gain_tc_second_warm) * 64'(deltaT) * 64'(deltaT)) <<< TC2_WARM_SHIFT);
        end else begin
            tcTerm = ((64'(gain_tc_first_chill) * 64'(deltaT)) <<< TC1_CHILL_SHIFT)
                + ((64'(gain_tc_second_chill) * 64'(deltaT) * 64'(deltaT)) <<< TC2_CHILL_SHIFT);
        end
        product = (scaled * ((64'sd1 <<< FACTOR_SHIFT) + tcTerm)) >>> FACTOR_SHIFT;
        next_y1 = clip(polarity ? -product : product, 64'(Y1_MIN), 64'(Y1_MAX));
    end

    logic signed [16:0] y1;
    logic signed [9:0] deltaT1;
    logic warm1, valid1;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            y1 <= '0;
            deltaT1 <= '0;
            warm1 <= 1'b0;
            valid1 <= 1'b0;
        end else begin
            y1 <= next_y1[16:0];
            deltaT1 <= deltaT;
            warm1 <= warm;
            valid1 <= sampleValid;
        end
    end

    // Offset stage: trim plus region drift, result held to 13 bits
    logic signed [63:0] drift, next_y2;
    always_comb begin
        drift = warm1 ? ((64'(offsetTcWarm) * 64'(deltaT1)) >>> OTC_WARM_SHIFT)
            : ((64'(offsetTcChill) * 64'(deltaT1)) >>> OTC_CHILL_SHIFT);
        next_y2 = clip(64'(y1) + 64'(offset_trim) + drift,
            64'(Y2_MIN), 64'(Y2_MAX));
    end

    logic signed [12:0] y2;
    logic valid2;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            y2 <= '0;
            valid2 <= 1'b0;
        end else begin
            y2 <= next_y2[12:0];
            valid2 <= valid1;
        end
    end

    // Linearisation: count breakpoints at or below the input, pick the
    // segment and interpolate; ends extrapolate from the outer segments
    logic signed [13:0] linIn;
    logic [BP_NUM-1:0] atOrAbove;
    always_comb linIn = polIn ? -14'(y2) : 14'(y2);

    generate
        for (genvar i = 0; i < BP_NUM; i++) begin : gCmp
            assign atOrAbove[i] = linIn >= 14'(segment_breakpoint[i]);
        end
    endgenerate

    // Equal neighbours give a jump rather than a divide by zero
    logic [4:0] hits;
    logic [3:0] seg;
    logic signed [31:0] xLo, xHi, yLo, span, lin, next_y3;
    always_comb begin
        hits = '0;
        for (int i = 0; i < BP_NUM; i++) begin
            hits = hits + 5'(atOrAbove[i]);
        end
        seg = (hits == 5'd0) ? 4'd0 : ((hits >= 5'd16) ? 4'd15 : 4'(hits - 5'd1));
        xLo = 32'(segment_breakpoint[seg]);
        xHi = 32'(segment_breakpoint[5'(seg) + 5'd1]);
        yLo = 32'(LIN_Y0) + 32'(LIN_STEP) * 32'(seg);
        span = xHi - xLo;
        if (span == 0) begin
            lin = (32'(linIn) >= xHi) ? yLo + 32'(LIN_STEP) : yLo;
        end else begin
            lin = yLo + ((32'(linIn) - xLo) * 32'(LIN_STEP)) / span;
        end
        lin = 32'(clip(64'(lin), -64'(LIN_LIMIT), 64'(LIN_LIMIT)));
        next_y3 = polOut ? -lin : lin;
    end

    logic signed [12:0] y3;
    logic valid3;
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            y3 <= '0;
            valid3 <= 1'b0;
        end else begin
            y3 <= next_y3[12:0];
            valid3 <= valid2;
        end
    end

    // Post gain and offset, shift to the unsigned code range, then clamp;
    // a low limit above the high one lets the high limit win
    logic signed [63:0] post, next_code;
    always_comb begin
        post = ((64'(y3) * 64'(post_gain_trim)) >>> POST_SHIFT)
            + 64'(post_offset_trim) + 64'(OUT_MID);
        next_code = clip(post, 64'sd0, 64'(OUT_MAX));
        if (next_code < 64'(low_clamp_limit)) begin
            next_code = 64'(low_clamp_limit);
        end
        if (next_code > 64'(high_clamp_limit)) begin
            next_code = 64'(high_clamp_limit);
        end
    end

    // Output code holds its last value between samples
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            outCode <= '0;
            outValid <= 1'b0;
        end else begin
            outValid <= valid3;
            if (valid3) begin
                outCode <= next_code[11:0];
            end
        end
    end
endmodule

// [bench/hall_trim_checker.sv]
/*
 * Port-level assertions for the sensor trim path.
 * Bound to every instance of the path; watches its ports only.
 */
module hall_trim_checker
    import hall_trim_pkg::*;
#(
    parameter int SAMPLE_W = 16,
    parameter int TEMP_W = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWr,
    input wire logic regRd,
    input wire logic [31:0] regRdData,
    input wire logic signed [SAMPLE_W-1:0] sampleIn,
    input wire logic sampleValid,
    input wire logic signed [TEMP_W-1:0] ambientTemp,
    input wire logic [11:0] outCode,
    input wire logic outValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] lowLim;
    logic [11:0] highLim;
    // Shadow of the clamp fields; limits must not move while samples are in flight
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            lowLim <= 12'h000;
            highLim <= HIGH_CLAMP_RESET;
        end else if (regWr && regAddr == REG_CLAMP) begin
            lowLim <= regWrData[11:0];
            highLim <= regWrData[27:16];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    sequence sampleTaken; sampleValid; endsequence
    sequence answerAfterPipe; ##4 outValid; endsequence
    sample_latency_a: assert property (sampleTaken |-> answerAfterPipe)
        else $error("no output code four cycles after a sample");
    no_spurious_a: assert property (!sampleValid |-> ##4 !outValid)
        else $error("output code without a sample");
    code_holds_a: assert property (!outValid |-> outCode == $past(outCode))
        else $error("output code moved between samples");
    high_clamp_a: assert property (outValid |-> outCode <= highLim)
        else $error("output code above high limit");
    low_clamp_a: assert property (outValid && lowLim <= highLim
        |-> outCode >= lowLim) else $error("output code below low limit");
    status_read_a: assert property (regRd && regAddr == REG_STATUS
        |=> regRdData == {20'h0, $past(outCode)}) else $error("status differs from code");
    clamp_read_a: assert property (regRd && regAddr == REG_CLAMP
        |=> regRdData == {4'h0, highLim, 4'h0, lowLim}) else $error("clamp readback wrong");
    hole_read_a: assert property (regRd && (regAddr[1:0] != 2'h0 || regAddr > 8'h80
        || (regAddr >= 8'h20 && regAddr < 8'h40)) |=> regRdData == 32'h0)
        else $error("unmapped read not zero");
    rd_holds_a: assert property (!regRd |=> $stable(regRdData))
        else $error("read data moved without a read");
endmodule
bind hall_signal_trim_path hall_trim_checker #(.SAMPLE_W(SAMPLE_W), .TEMP_W(TEMP_W)) chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sampleIn(sampleIn),
    .sampleValid(sampleValid), .ambientTemp(ambientTemp), .outCode(outCode),
    .outValid(outValid)
);

// [bench/hall_sample_source.sv]
/*
 * Behavioural converter source and output collector for the trim path.
 * Assumes the bench clock; every drive after the quiet start values follows a rising edge.
 */
module hall_sample_source (
    input wire logic clkSys,
    output logic signed [15:0] sampleIn,
    output logic sampleValid,
    output logic signed [7:0] ambientTemp,
    input wire logic [11:0] outCode,
    input wire logic outValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] got[$];
    // Quiet lines at start
    initial begin
        sampleIn = 16'sh0;
        sampleValid = 1'b0;
        ambientTemp = 8'sh19;
    end
    // One sample per call; successive calls stream back to back
    task automatic sendOne(input logic signed [15:0] s, input logic signed [7:0] t);
        @(posedge clkSys);
        sampleValid <= 1'b1;
        sampleIn <= s;
        ambientTemp <= t;
    endtask
    // Idle lines wander so a stale value is never mistaken for data
    task automatic idle();
        @(posedge clkSys);
        sampleValid <= 1'b0;
        sampleIn <= ~sampleIn;
        ambientTemp <= ~ambientTemp;
    endtask
    // Encoder side keeps every qualified code in arrival order
    always @(posedge clkSys) begin
        if (outValid === 1'b1) begin
            got.push_back(outCode);
        end
    end
endmodule

// [bench/hall_signal_trim_path_tb.sv]
/*
 * Self-checking bench of the sensor trim path: registers are driven here,
 * samples come from the source model. Assumes the port checker is bound.
 */
`define CHK(a, b) begin \
    cmpCount++; \
    if ((a) !== (b)) begin \
        nMismatch++; \
        $display("mismatch at %0t: got %0h expected %0h", $time, a, b); \
    end \
end
module hall_signal_trim_path_tb import hall_trim_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        int pol, coarse, fine, tc1w, tc1c, tc2w, tc2c, ofs;
        int otcW, otcC, low, high, polIn, polOut, postOfs;
    } cfg_t;
    logic clkSys = 1'b0;
    logic sysRst = 1'b1;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0000_0000;
    logic [31:0] regRdData;
    logic signed [15:0] sampleIn;
    logic signed [7:0] ambientTemp;
    logic sampleValid, outValid;
    logic [11:0] outCode, lastCode;
    logic [11:0] expQ[$];
    int qs[$], qt[$];
    int nMismatch = 0;
    int cmpCount = 0;
    cfg_t cfg;
    // 50 MHz system clock
    initial begin
        forever #10 clkSys = ~clkSys;
    end
    hall_signal_trim_path #(.SAMPLE_W(16), .TEMP_W(8)) dut (
        .clk_sys(clkSys), .sys_rst(sysRst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sampleIn(sampleIn),
        .sampleValid(sampleValid), .ambientTemp(ambientTemp), .outCode(outCode),
        .outValid(outValid)
    );
    hall_sample_source src (
        .clkSys(clkSys), .sampleIn(sampleIn), .sampleValid(sampleValid),
        .ambientTemp(ambientTemp), .outCode(outCode), .outValid(outValid)
    );
    function automatic longint clip(input longint v, input longint lo, input longint hi);
        return v < lo ? lo : (v > hi ? hi : v);
    endfunction
    // Reference arithmetic; the default table is an identity below 2047, and
    // every case here stays under that or clips past the top segment
    function automatic logic [11:0] model(input longint smp, input longint t);
        longint d, y, tc;
        d = t - 25;
        y = smp <<< (cfg.coarse > 5 ? 5 : cfg.coarse);
        y = (y * (1024 + cfg.fine)) >>> 11;
        tc = d >= 0 ? ((cfg.tc1w * d) <<< 7) + cfg.tc2w * d * d
            : ((cfg.tc1c * d) <<< 8) + ((cfg.tc2c * d * d) <<< 2);
        y = (y * ((64'sh1 <<< 25) + tc)) >>> 25;
        y = clip(cfg.pol != 0 ? -y : y, -65536, 65535);
        y = y + cfg.ofs + (d >= 0 ? (cfg.otcW * d) >>> 6 : (cfg.otcC * d) >>> 5);
        y = clip(clip(y, -4096, 4095) * (cfg.polIn != 0 ? -1 : 1), -2304, 2304);
        y = (y * (cfg.polOut != 0 ? -2047 : 2047)) >>> 11;
        y = clip(clip(y + cfg.postOfs + 2048, 0, 4095), cfg.low, 4095);
        return 12'(y > cfg.high ? cfg.high : y);
    endfunction
    // Register port: one-cycle strobes, read data from the following cycle, held until the next read
    task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
        @(posedge clkSys);
        regWr <= 1'b1;
        regRd <= 1'b0;
        regAddr <= a;
        regWrData <= d;
    endtask
    task automatic checkReg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clkSys);
        regRd <= 1'b1;
        regWr <= 1'b0;
        regAddr <= a;
        @(posedge clkSys);
        regRd <= 1'b0;
        #1 `CHK(regRdData, e)
    endtask
    task automatic doReset();
        sysRst <= 1'b1;
        repeat (10) @(posedge clkSys);
        sysRst <= 1'b0;
        src.got.delete();
    endtask
    task automatic cfgDefault();
        cfg = '{default: 0};
        cfg.fine = 1024;
        cfg.high = 4095;
    endtask
    // Top breakpoint pulled to 0x7FF so the table stays monotonic
    task automatic applyCfg();
        regWrite(REG_SENS_TRIM, {16'h0, cfg.pol[0], cfg.coarse[2:0], 1'b0, cfg.fine[10:0]});
        regWrite(REG_GAIN_TC_FIRST, {9'h0, cfg.tc1c[10:0], 1'b0, cfg.tc1w[10:0]});
        regWrite(REG_GAIN_TC_SECOND, {10'h0, cfg.tc2c[9:0], 2'h0, cfg.tc2w[9:0]});
        regWrite(REG_OFFSET_TRIM, {16'h0, cfg.ofs[15:0]});
        regWrite(REG_OFFSET_TC, {8'h0, cfg.otcC[11:0], cfg.otcW[11:0]});
        regWrite(REG_CLAMP, {4'h0, cfg.high[11:0], 4'h0, cfg.low[11:0]});
        regWrite(REG_POST, {2'h0, cfg.polOut[0], cfg.polIn[0], cfg.postOfs[11:0], 16'h07FF});
        regWrite(8'h80, 32'h0000_07FF);
        @(posedge clkSys);
        regWr <= 1'b0;
    endtask
    task automatic push(input int s, input int t);
        qs.push_back(s);
        qt.push_back(t);
        expQ.push_back(model(s, t));
    endtask
    // Stream the queued samples back to back, then match codes in order
    task automatic flush();
        int n;
        logic [11:0] got;
        n = qs.size();
        foreach (qs[i]) src.sendOne(16'(qs[i]), 8'(qt[i]));
        src.idle();
        for (int w = 0; w < 20 && src.got.size() < n; w++) @(posedge clkSys);
        `CHK(src.got.size(), n)
        foreach (expQ[i]) begin
            got = src.got.size() > 0 ? src.got.pop_front() : ~expQ[i];
            `CHK(got, expQ[i])
        end
        lastCode = expQ[$];
        qs.delete();
        qt.delete();
        expQ.delete();
    endtask
    task automatic sendCase(input int a, input int b);
        applyCfg();
        push(a, 25);
        push(b, 25);
        flush();
    endtask
    task automatic resetValues();
        checkReg(REG_SENS_TRIM, 32'h0000_0400);
        checkReg(REG_CLAMP, 32'h0FFF_0000);
        checkReg(REG_POST, 32'h0000_07FF);
        checkReg(REG_BREAKPOINT, 32'h0000_0800);
        checkReg(8'h7C, 32'h0000_0700);
        $display("test reset values done");
    endtask
    // All-ones writes expose each field width; holes and read-only places stay 0
    task automatic fieldWidths();
        logic [7:0] ad[12] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C,
            8'h20, 8'h41, 8'h80, 8'h84};
        logic [31:0] mk[12] = '{32'h0000_F7FF, 32'h007F_F7FF, 32'h003F_F3FF, 32'h0000_FFFF,
            32'h00FF_FFFF, 32'h0FFF_0FFF, 32'h3FFF_0FFF, 0, 0, 0, 32'h0000_0FFF, 0};
        foreach (ad[i]) regWrite(ad[i], 32'hFFFF_FFFF);
        foreach (ad[i]) checkReg(ad[i], mk[i]);
        $display("test field widths done");
    endtask
    task automatic gainSteps();
        cfgDefault();
        for (int c = 0; c < 8; c++) begin
            cfg.coarse = c;
            sendCase(-37, 32767);
        end
        cfg.coarse = 2;
        cfg.fine = 0;
        sendCase(300, -300);
        cfg.fine = 2047;
        sendCase(300, -300);
        cfg.pol = 1;
        sendCase(300, -300);
        $display("test gain steps done");
    endtask
    task automatic tempRegions();
        int temps[6] = '{-30, 0, 24, 25, 26, 85};
        cfgDefault();
        cfg = '{0, 0, 1024, 1000, -1000, 500, -200, 0, 640, -320, 0, 4095, 0, 0, 0};
        applyCfg();
        foreach (temps[i]) push(1000, temps[i]);
        foreach (temps[i]) push(-700, temps[i]);
        flush();
        $display("test temperature regions done");
    endtask
    task automatic outputLimits();
        cfgDefault();
        cfg.ofs = 500;
        cfg.polIn = 1;
        sendCase(0, -200);
        cfg.polIn = 0;
        cfg.polOut = 1;
        sendCase(0, -200);
        cfg.polOut = 0;
        cfg.postOfs = -2048;
        sendCase(0, -200);
        cfg.postOfs = 2047;
        sendCase(0, -200);
        cfg = '{0, 0, 1024, 0, 0, 0, 0, 32767, 0, 0, 256, 3584, 0, 0, 0};
        sendCase(0, 0);
        cfg.ofs = -32768;
        sendCase(0, 0);
        checkReg(REG_STATUS, {20'h0, lastCode});
        cfg = '{0, 0, 1024, 0, 0, 0, 0, 0, 0, 0, 2304, 2048, 0, 0, 0};
        sendCase(0, 100);
        $display("test output limits done");
    endtask
    // Two equal neighbours at zero: inputs at or past them jump a whole step
    task automatic segmentTable();
        cfgDefault();
        applyCfg();
        regWrite(REG_BREAKPOINT + 8'h24, 32'h0000_0000);
        @(posedge clkSys);
        regWr <= 1'b0;
        qs = '{100, -100, 0};
        qt = '{25, 25, 25};
        // Segment 9 from (0, 256) to (512, 512); segment 7 stays an identity
        expQ = '{12'h931, 12'h79C, 12'h8FF};
        flush();
        $display("test segment table done");
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Whole run is a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge clkSys);
        nMismatch++;
        give_verdict();
    end
    initial begin
        doReset();
        resetValues();
        fieldWidths();
        doReset();
        gainSteps();
        tempRegions();
        outputLimits();
        segmentTable();
        give_verdict();
    end
endmodule
